/* hw/osc_clock_ctrl.sv */
// Oscillator control register with AXI4-Lite access and clock gating
`timescale 1ns/1ps
module osc_clock_ctrl #(
  parameter int count_limit = osc_pkg::stable_cycles
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_enable,
  input  wire logic        raw_crystal_clock,
  input  wire logic        run_mode,
  input  wire logic        stop_mode,
  input  wire logic        vlls_wake,
  output logic             system_osc_clock,
  output logic             peripheral_ref_clock,
  output logic             low_power_32k_clock,
  output logic             osc_stable,
  output osc_pkg::osc_ctrl_type ctrl_out
);
  // There is no interrupt request output: nothing here can signal one [RL11]
  logic [7:0]             osc_control;
  logic                   aw_held;
  logic                   w_held;
  logic [11:0]            aw_addr;
  logic [7:0]             w_data;
  logic                   w_lane0;
  logic                   crystal_prev;
  logic                   crystal_edge;
  logic                   stable_now;
  logic                   ref_before_stop;
  logic                   stop_prev;
  logic                   ref_gate;
  logic                   sys_gate;
  logic                   keep_in_stop;
  osc_pkg::osc_state_type state;
  osc_pkg::osc_state_type next_state;

  // Address and data may arrive in either order; each is held until both exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= osc_pkg::resp_okay;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[11:2] == osc_pkg::osc_control_offset[11:2])
                      ? osc_pkg::resp_okay : osc_pkg::resp_slverr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Very-low-leakage wake acts like reset; low-leakage stop simply holds
  always_ff @(posedge aclk) begin
    if (!aresetn || vlls_wake) begin
      osc_control <= osc_pkg::osc_control_reset; // [RL1] [RL10]
    end else if (aw_held && w_held && w_lane0
                 && aw_addr[11:2] == osc_pkg::osc_control_offset[11:2]) begin
      osc_control <= w_data & osc_pkg::osc_control_mask; // [RL4] [RL12]
    end
  end

  // Reads of any other word answer SLVERR with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= osc_pkg::resp_okay;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (s_axi_araddr[11:2] == osc_pkg::osc_control_offset[11:2]) begin
        s_axi_rdata <= {24'h000000, osc_control}; // [RL1] [RL4]
        s_axi_rresp <= osc_pkg::resp_okay;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= osc_pkg::resp_slverr;
      end
    end else begin
      s_axi_arready <= s_axi_arvalid;
    end
  end

  // Raw crystal is sampled as a synchronous level; its rising edges feed the counter
  always_ff @(posedge aclk) begin
    crystal_prev <= raw_crystal_clock;
  end
  assign crystal_edge = raw_crystal_clock && !crystal_prev;

  osc_stability #(
    .count_limit (count_limit)
  ) u_stability (
    .aclk         (aclk),
    .osc_enable   (osc_enable),
    .crystal_edge (crystal_edge),
    .stable       (stable_now)
  );

  always_comb begin
    next_state = state;
    case (state)
      osc_pkg::osc_off:    next_state = osc_enable ? osc_pkg::osc_start : osc_pkg::osc_off;
      osc_pkg::osc_start:  next_state = !osc_enable ? osc_pkg::osc_off
                                      : (stable_now ? osc_pkg::osc_stable : osc_pkg::osc_start);
      osc_pkg::osc_stable: next_state = osc_enable ? osc_pkg::osc_stable : osc_pkg::osc_off;
      default:             next_state = osc_pkg::osc_off;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= osc_pkg::osc_off;
    end else begin
      state <= next_state; // [RL9]
    end
  end

  // Capture bit 7 as it stands on Stop entry, so a late set cannot start it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_prev       <= 1'b0;
      ref_before_stop <= 1'b0;
    end else begin
      stop_prev <= stop_mode;
      if (stop_mode && !stop_prev) begin
        ref_before_stop <= osc_control[osc_pkg::ref_on_bit]; // [RL3]
      end
    end
  end

  // On the Stop entry cycle the capture is not loaded yet, so the live bit stands in
  assign keep_in_stop = osc_control[osc_pkg::stop_keep_bit]
                        && (stop_prev ? ref_before_stop
                                      : osc_control[osc_pkg::ref_on_bit]); // [RL3]

  // Enables change only while the raw clock is low so no gated pulse is cut short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_gate <= 1'b0;
      sys_gate <= 1'b0;
    end else if (!raw_crystal_clock) begin
      ref_gate <= (state == osc_pkg::osc_stable) && osc_control[osc_pkg::ref_on_bit]
                  && (!stop_mode || keep_in_stop); // [RL2] [RL3] [RL12]
      sys_gate <= (state == osc_pkg::osc_stable) && run_mode && !stop_mode; // [RL7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_osc_clock     <= 1'b0;
      peripheral_ref_clock <= 1'b0;
      low_power_32k_clock  <= 1'b0;
      osc_stable           <= 1'b0;
      ctrl_out             <= '0;
    end else begin
      system_osc_clock     <= sys_gate && raw_crystal_clock; // [RL7] [RL8]
      peripheral_ref_clock <= ref_gate && raw_crystal_clock; // [RL2]
      low_power_32k_clock  <= (state == osc_pkg::osc_stable) && raw_crystal_clock; // [RL7]
      osc_stable           <= (state == osc_pkg::osc_stable);
      ctrl_out.periph_ref_clock_on <= osc_control[osc_pkg::ref_on_bit]; // [RL2]
      ctrl_out.ref_clock_stop_keep <= osc_control[osc_pkg::stop_keep_bit]; // [RL3]
      ctrl_out.load_cap_2pf        <= osc_control[osc_pkg::cap_2pf_bit]; // [RL5]
      ctrl_out.load_cap_4pf        <= osc_control[osc_pkg::cap_4pf_bit]; // [RL5]
      ctrl_out.load_cap_8pf        <= osc_control[osc_pkg::cap_8pf_bit]; // [RL5]
      ctrl_out.load_cap_16pf       <= osc_control[osc_pkg::cap_16pf_bit]; // [RL5]
    end
  end
endmodule

/* hw/osc_pkg.sv */
// Constants and types for the crystal oscillator control block
// Summary of operation
// [RL1] One 8-bit read/write control register, cleared to zero at reset.
// [RL2] Bit 7 gates the peripheral reference clock on or off.
// [RL3] Bit 5 keeps reference clock in Stop only if bit 7 set before entry.
// [RL4] Bits 6 and 4 read zero; writes to them are ignored.
// [RL5] Bits 3..0 switch in 2, 4, 8 and 16 pF load capacitors.
// [RL6] Software leaves configuration unchanged once oscillator produces clocks.
// [RL7] Three clocks: system clock run-only, reference and 32k in low power.
// [RL8] Output stays gated until 4096 raw crystal cycles are counted.
// [RL9] No own reset state; counter clears while oscillator is disabled.
// [RL10] Settings held in low-leakage stop; reset after very-low-leakage wake.
// [RL11] The block never raises an interrupt.
// [RL12] Register updates on bus clock; clock enables switch without glitches. The 32k clock follows state at any raw clock phase.
package osc_pkg;

  localparam logic [11:0] osc_control_offset = 12'h000;
  localparam logic [7:0]  osc_control_reset  = 8'h00;
  localparam logic [7:0]  osc_control_mask   = 8'hAF;
  localparam int          ref_on_bit         = 7;
  localparam int          stop_keep_bit      = 5;
  localparam int          cap_2pf_bit        = 3;
  localparam int          cap_4pf_bit        = 2;
  localparam int          cap_8pf_bit        = 1;
  localparam int          cap_16pf_bit       = 0;
  localparam int          stable_cycles      = 4096;
  localparam logic [1:0]  resp_okay          = 2'b00;
  localparam logic [1:0]  resp_slverr        = 2'b10;

  typedef struct packed {
    logic periph_ref_clock_on;
    logic ref_clock_stop_keep;
    logic load_cap_2pf;
    logic load_cap_4pf;
    logic load_cap_8pf;
    logic load_cap_16pf;
  } osc_ctrl_type;

  typedef enum logic [2:0] {
    osc_off    = 3'b001,
    osc_start  = 3'b010,
    osc_stable = 3'b100
  } osc_state_type;

endpackage

/* hw/osc_stability.sv */
// Start-up counter that qualifies the raw crystal clock as stable
`timescale 1ns/1ps
module osc_stability #(
  parameter int count_limit = osc_pkg::stable_cycles
) (
  input  wire logic aclk,
  input  wire logic osc_enable,
  input  wire logic crystal_edge,
  output logic      stable
);
  logic [12:0] count;

  // The 13-bit counter cannot hold a larger limit
  if (count_limit < 1 || count_limit > 8191) begin : g_limit_check
    $error("count_limit out of range");
  end

  // No reset of its own: disabling the oscillator is what clears it
  always_ff @(posedge aclk) begin
    if (!osc_enable) begin
      count <= 13'h0000; // [RL9]
    end else if (crystal_edge && count != 13'(count_limit)) begin
      count <= count + 13'h0001; // [RL8]
    end
  end

  always_ff @(posedge aclk) begin
    stable <= osc_enable && (count == 13'(count_limit)); // [RL8]
  end
endmodule

/* tb/crystal_model.sv */
// Crystal source model driving the raw clock input
`timescale 1ns/1ps
module crystal_model #(parameter realtime half = 6.0) (
  input wire logic run,
  output logic crystal_drive_output
);
  initial begin
    crystal_drive_output = 1'h0;
    // Odd-nanosecond edges stay clear of the even-time aclk edges
    #1;
    // Held low, not toggling, while the oscillator is disabled
    forever #(half) crystal_drive_output = run ? ~crystal_drive_output : 1'h0;
  end
endmodule

/* tb/osc_clock_ctrl_monitor.sv */
// Port checks for the oscillator control block
`timescale 1ns/1ps
module osc_clock_ctrl_monitor #(
  parameter int count_limit = osc_pkg::stable_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_enable,
  input wire logic raw_crystal_clock,
  input wire logic run_mode,
  input wire logic stop_mode,
  input wire logic vlls_wake,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic system_osc_clock,
  input wire logic peripheral_ref_clock,
  input wire logic low_power_32k_clock,
  input wire logic osc_stable,
  input wire osc_pkg::osc_ctrl_type ctrl_out
);
  logic        raw_prev;
  logic [13:0] raw_edges;

  // Independent count of sampled raw rising edges since the oscillator was enabled
  always_ff @(posedge aclk) begin
    raw_prev <= raw_crystal_clock;
    if (!osc_enable) begin
      raw_edges <= 14'h0000;
    end else if (raw_crystal_clock && !raw_prev && raw_edges != 14'h3FFF) begin
      raw_edges <= raw_edges + 14'h0001;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_nokeep; (stop_mode && !ctrl_out.ref_clock_stop_keep)[*6]; endsequence
  sequence s_idle; (!osc_stable)[*4]; endsequence
  property p_stop_off; s_nokeep |-> !peripheral_ref_clock; endproperty
  a_stop_off: assert property (p_stop_off) else $error("ref in stop");
  property p_ref_off; (!ctrl_out.periph_ref_clock_on)[*6] |-> !peripheral_ref_clock; endproperty
  a_ref_off: assert property (p_ref_off) else $error("ref disabled");
  property p_run_only; (!run_mode)[*6] |-> !system_osc_clock; endproperty
  a_run_only: assert property (p_run_only) else $error("sys out of run");
  property p_stop_sys; stop_mode[*6] |-> !system_osc_clock; endproperty
  a_stop_sys: assert property (p_stop_sys) else $error("sys in stop");
  property p_gated; s_idle |->
    {system_osc_clock, peripheral_ref_clock, low_power_32k_clock} == 3'h0; endproperty
  a_gated: assert property (p_gated) else $error("clock before stable");
  property p_clear; (!osc_enable)[*4] |-> !osc_stable; endproperty
  a_clear: assert property (p_clear) else $error("stable when off");
  property p_count; $rose(osc_stable) |-> int'(raw_edges) >= count_limit; endproperty
  a_count: assert property (p_count) else $error("stable too soon");
  property p_wake; vlls_wake |-> ##[2:3] ctrl_out == 6'h00; endproperty
  a_wake: assert property (p_wake) else $error("wake kept fields");
  property p_prompt; $rose(int'(raw_edges) == count_limit) |-> ##[1:4] osc_stable; endproperty
  a_prompt: assert property (p_prompt) else $error("stable too late");
  property p_rsvd; s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF_FF50) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
endmodule
bind osc_clock_ctrl osc_clock_ctrl_monitor #(.count_limit(count_limit)) i_mon (.aclk,
  .aresetn, .osc_enable, .raw_crystal_clock, .run_mode, .stop_mode, .vlls_wake,
  .s_axi_rvalid, .s_axi_rdata, .system_osc_clock, .peripheral_ref_clock,
  .low_power_32k_clock, .osc_stable, .ctrl_out);

/* tb/testbench.sv */
// Self-checking bench for the oscillator control block
`timescale 1ns/1ps
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready;
  logic s_axi_rready, osc_enable, run_mode, stop_mode, vlls_wake, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, raw_crystal_clock;
  logic system_osc_clock, peripheral_ref_clock, low_power_32k_clock, osc_stable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] seen;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  osc_pkg::osc_ctrl_type ctrl_out;
  int n_fail, num_checks;
  osc_clock_ctrl #(.count_limit(8)) i_dut (.*);
  crystal_model i_crystal_drive_output (.run(osc_enable), .crystal_drive_output(raw_crystal_clock));
  initial forever #2 aclk = ~aclk;
  task chk(bit ok, string m);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Each valid drops at its own handshake; bready and rready simply stay high
  task automatic xfer(bit w, logic [11:0] a, logic [31:0] v, logic [3:0] s, logic [1:0] e);
    int n;
    n = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, v, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 60);
    chk(n < 60, "no response");
    if (n == 60) conclude();
    if (w) chk(s_axi_bresp === e, "write response");
    else chk(s_axi_rresp === e && (e !== 2'h0 || s_axi_rdata === v), "read data");
  endtask
  task settle();
    osc_enable <= 1'h1;
    for (int i = 0; i < 200 && osc_stable !== 1'h1; i++) @(posedge aclk);
    chk(osc_stable === 1'h1, "stable");
    if (osc_stable !== 1'h1) conclude();
  endtask
  task watch(logic [2:0] x, string m);
    seen = 3'h0;
    repeat (8) @(posedge aclk);
    repeat (40) @(posedge aclk)
      seen |= {system_osc_clock, peripheral_ref_clock, low_power_32k_clock};
    chk(seen === x, m);
  endtask
  initial begin
    {aclk, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, osc_enable, stop_mode} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, vlls_wake, aresetn} = 62'h0;
    {s_axi_bready, s_axi_rready, run_mode} = 3'h7;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    xfer(0, 12'h000, 32'h0, 4'h0, 2'h0);
    xfer(1, 12'h000, 32'hFFFFFFFF, 4'hF, 2'h0);
    xfer(0, 12'h000, 32'hAF, 4'h0, 2'h0);
    chk(ctrl_out === 6'h3F, "fields");
    xfer(1, 12'h000, 32'h0, 4'h0, 2'h0);
    xfer(1, 12'h004, 32'h0, 4'hF, 2'h2);
    xfer(0, 12'h000, 32'hAF, 4'h0, 2'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1, 12'h000, 32'h1 << i, 4'hF, 2'h0);
      xfer(0, 12'h000, 32'h1 << i, 4'h0, 2'h0);
      chk(ctrl_out === 6'h01 << i, "load");
    end
    xfer(1, 12'h000, 32'hA0, 4'hF, 2'h0);
    settle();
    watch(3'h7, "run");
    {stop_mode, run_mode} <= 2'h2;
    watch(3'h3, "keep");
    {stop_mode, run_mode, osc_enable} <= 3'h2;
    watch(3'h0, "off");
    xfer(1, 12'h000, 32'h80, 4'hF, 2'h0);
    settle();
    {stop_mode, run_mode} <= 2'h2;
    watch(3'h1, "drop");
    vlls_wake <= 1'h1;
    @(posedge aclk);
    vlls_wake <= 1'h0;
    xfer(0, 12'h000, 32'h0, 4'h0, 2'h0);
    {stop_mode, run_mode} <= 2'h1;
    watch(3'h5, "no ref");
    conclude();
  end
endmodule
